// ### hdl/ocd_pkg.sv
// Purpose: Constants and types for the opcode decode and cycle table
// Assumes: One-byte opcodes arrive on the core clock
// Notes:   Cycle counts are processor clock states per instruction
//
// Behaviour
// [RULE_01] 01 dest src with no memory field copies a register in 5 cycles.
// [RULE_02] 01110 src stores a register to memory at H and L in 7 cycles.
// [RULE_03] 01 dest 110 loads a register from memory at H and L in 7 cycles.
// [RULE_04] Add 10000 src and add with carry 10001 src take 4 cycles.
// [RULE_05] Subtract 10010 src and with borrow 10011 src take 4 cycles.
// [RULE_06] AND 10100 src, XOR 10101 src and OR 10110 src take 4 cycles.
// [RULE_07] Compare 10111 src sets only the flags and takes 4 cycles.
// [RULE_08] Add memory 10000110 and with carry 10001110 take 7 cycles.
// [RULE_09] Subtract memory 10010110 and with borrow 10011110 take 7 cycles.
// [RULE_10] Six conditional returns take 5 cycles, or 11 when taken.
// [RULE_11] Immediate loads of BC, DE, HL and SP take 10 cycles.
// [RULE_12] Pushes of BC, DE and HL onto the stack take 11 cycles.
// [RULE_13] Fields: B 000 C 001 D 010 E 011 H 100 L 101 A 111, 110 is memory.
// [RULE_14] Every decoded opcode carries its cycle count to the sequencer.
package ocd_pkg;

    typedef enum logic [4:0] {
        OCD_NONE, OCD_COPY_OP, OCD_STORE_MEM, OCD_LOAD_MEM,
        OCD_ADD, OCD_ADD_CARRY, OCD_SUB, OCD_MINUS_BORROW_OP,
        OCD_AND_ACC_OP, OCD_XOR_ACC_OP, OCD_OR_ACC_OP,
        OCD_COMPARE_ACC_OP, OCD_RET_COND, OCD_LOAD_PAIR_IMMEDIATE,
        OCD_PUSH_PAIR
    } ocd_op_type;

    typedef enum logic [2:0] {
        OCD_RET_IF_NONZERO, OCD_RET_IF_ZERO, OCD_RET_IF_ODD_PARITY,
        OCD_RET_IF_EVEN_PARITY, OCD_RET_IF_PLUS, OCD_RET_IF_NEGATIVE
    } ocd_cond_type;

    localparam logic [2:0] OCD_REG_B   = 3'h0;
    localparam logic [2:0] OCD_REG_C   = 3'h1;
    localparam logic [2:0] OCD_REG_D   = 3'h2;
    localparam logic [2:0] OCD_REG_E   = 3'h3;
    localparam logic [2:0] OCD_REG_H   = 3'h4;
    localparam logic [2:0] OCD_REG_L   = 3'h5;
    localparam logic [2:0] OCD_REG_MEM = 3'h6;
    localparam logic [2:0] OCD_REG_A   = 3'h7;

    localparam logic [1:0] OCD_PAIR_BC = 2'h0;
    localparam logic [1:0] OCD_PAIR_DE = 2'h1;
    localparam logic [1:0] OCD_PAIR_HL = 2'h2;
    localparam logic [1:0] OCD_PAIR_SP = 2'h3;

    localparam logic [7:0] OCD_OPC_RET_ZERO    = 8'hC8;
    localparam logic [7:0] OCD_OPC_RET_NONZERO = 8'hC0;
    localparam logic [7:0] OCD_OPC_RET_PLUS    = 8'hF0;
    localparam logic [7:0] OCD_OPC_RET_NEG     = 8'hF8;
    localparam logic [7:0] OCD_OPC_RET_EVEN    = 8'hE8;
    localparam logic [7:0] OCD_OPC_RET_ODD     = 8'hE0;
    localparam logic [7:0] OCD_OPC_LDBC        = 8'h01;
    localparam logic [7:0] OCD_OPC_LDDE        = 8'h11;
    localparam logic [7:0] OCD_OPC_LDHL        = 8'h21;
    localparam logic [7:0] OCD_OPC_LDSP        = 8'h31;
    localparam logic [7:0] OCD_OPC_PSBC        = 8'hC5;
    localparam logic [7:0] OCD_OPC_PSDE        = 8'hD5;
    localparam logic [7:0] OCD_OPC_PSHL        = 8'hE5;

    localparam logic [4:0] OCD_CYC_ALU_REG = 5'h04;
    localparam logic [4:0] OCD_CYC_COPY    = 5'h05;
    localparam logic [4:0] OCD_CYC_MEM     = 5'h07;
    localparam logic [4:0] OCD_CYC_LDPAIR  = 5'h0A;
    localparam logic [4:0] OCD_CYC_PUSH    = 5'h0B;
    localparam logic [4:0] OCD_CYC_RET_NOT = 5'h05;
    localparam logic [4:0] OCD_CYC_RET_TAK = 5'h0B;

endpackage

// ### hdl/ocd_decoder.sv
// Purpose: Registered one-byte opcode decoder with cycle counts
// Assumes: Opcode byte and strobe come from same-clock fetch logic
// Notes:   Results appear one clock after the strobe
`timescale 1ns/1ps
module ocd_decoder
    import ocd_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    input  wire logic         opValid,
    input  wire logic [7:0]   opcode,
    output ocd_op_type        opClass,
    output logic              decValid,
    output logic              decKnown,
    output logic [2:0]        destField,
    output logic [2:0]        srcField,
    output logic [1:0]        pairSel,
    output ocd_cond_type      retCond,
    output logic [4:0]        cycleCount,
    output logic [4:0]        cycleCountTaken
);

    // Decode results ahead of the output stage
    ocd_op_type   next_opClass;
    ocd_cond_type next_retCond;
    logic [1:0]   next_pairSel;
    logic [2:0]   next_destField;
    logic [2:0]   next_srcField;
    logic [4:0]   next_cycles;
    logic [4:0]   next_cyclesTaken;
    logic         next_decKnown;
    logic         destIsMem;
    logic         srcIsMem;

    // Operand fields of the byte
    always_comb begin
        next_destField = opcode[5:3]; // [RULE_13]
        next_srcField  = opcode[2:0]; // [RULE_13]
        next_pairSel   = opcode[5:4];
        destIsMem      = (opcode[5:3] == OCD_REG_MEM); // [RULE_13]
        srcIsMem       = (opcode[2:0] == OCD_REG_MEM); // [RULE_13]
    end

    // Operation class
    always_comb begin
        next_opClass = OCD_NONE;
        case (opcode[7:6])
            2'h1: begin
                if (destIsMem && srcIsMem) begin
                    // Halt pattern stays undecoded
                    next_opClass = OCD_NONE;
                end else if (destIsMem) begin
                    next_opClass = OCD_STORE_MEM; // [RULE_02]
                end else if (srcIsMem) begin
                    next_opClass = OCD_LOAD_MEM; // [RULE_03]
                end else begin
                    next_opClass = OCD_COPY_OP; // [RULE_01]
                end
            end
            2'h2: begin
                case (opcode[5:3])
                    3'h0: next_opClass = OCD_ADD; // [RULE_04]
                    3'h1: next_opClass = OCD_ADD_CARRY; // [RULE_04]
                    3'h2: next_opClass = OCD_SUB; // [RULE_05]
                    3'h3: next_opClass = OCD_MINUS_BORROW_OP; // [RULE_05]
                    3'h4: next_opClass = OCD_AND_ACC_OP; // [RULE_06]
                    3'h5: next_opClass = OCD_XOR_ACC_OP; // [RULE_06]
                    3'h6: next_opClass = OCD_OR_ACC_OP; // [RULE_06]
                    default: next_opClass = OCD_COMPARE_ACC_OP; // [RULE_07]
                endcase
            end
            default: begin
                case (opcode)
                    OCD_OPC_RET_ZERO, OCD_OPC_RET_NONZERO,
                    OCD_OPC_RET_PLUS, OCD_OPC_RET_NEG,
                    OCD_OPC_RET_EVEN, OCD_OPC_RET_ODD: begin
                        next_opClass = OCD_RET_COND; // [RULE_10]
                    end
                    OCD_OPC_LDBC, OCD_OPC_LDDE, OCD_OPC_LDHL,
                    OCD_OPC_LDSP: begin
                        next_opClass = OCD_LOAD_PAIR_IMMEDIATE; // [RULE_11]
                    end
                    OCD_OPC_PSBC, OCD_OPC_PSDE, OCD_OPC_PSHL: begin
                        next_opClass = OCD_PUSH_PAIR; // [RULE_12]
                    end
                    default: begin
                        next_opClass = OCD_NONE;
                    end
                endcase
            end
        endcase
    end

    always_comb begin
        next_decKnown = (next_opClass != OCD_NONE);
    end

    // Cycle counts follow the class
    always_comb begin
        next_cycles      = 5'h00;
        next_cyclesTaken = 5'h00;
        case (next_opClass)
            OCD_COPY_OP: begin
                next_cycles = OCD_CYC_COPY; // [RULE_01]
            end
            OCD_STORE_MEM, OCD_LOAD_MEM: begin
                next_cycles = OCD_CYC_MEM; // [RULE_02] [RULE_03]
            end
            OCD_ADD, OCD_ADD_CARRY, OCD_SUB, OCD_MINUS_BORROW_OP,
            OCD_AND_ACC_OP, OCD_XOR_ACC_OP, OCD_OR_ACC_OP,
            OCD_COMPARE_ACC_OP: begin
                // Memory source costs the extra read
                if (srcIsMem) begin
                    next_cycles = OCD_CYC_MEM; // [RULE_08] [RULE_09]
                end else begin
                    next_cycles = OCD_CYC_ALU_REG; // [RULE_04] [RULE_05]
                end
            end
            OCD_RET_COND: begin
                next_cycles      = OCD_CYC_RET_NOT; // [RULE_10]
                next_cyclesTaken = OCD_CYC_RET_TAK; // [RULE_10]
            end
            OCD_LOAD_PAIR_IMMEDIATE: begin
                next_cycles = OCD_CYC_LDPAIR; // [RULE_11]
            end
            OCD_PUSH_PAIR: begin
                next_cycles = OCD_CYC_PUSH; // [RULE_12]
            end
            default: begin
                next_cycles = 5'h00;
            end
        endcase
        // Only returns differ between taken and not taken
        if (next_opClass != OCD_RET_COND) begin
            next_cyclesTaken = next_cycles;
        end
    end

    // Condition tested by a conditional return
    always_comb begin
        case (opcode)
            OCD_OPC_RET_ZERO: begin
                next_retCond = OCD_RET_IF_ZERO; // [RULE_10]
            end
            OCD_OPC_RET_PLUS: begin
                next_retCond = OCD_RET_IF_PLUS; // [RULE_10]
            end
            OCD_OPC_RET_NEG: begin
                next_retCond = OCD_RET_IF_NEGATIVE; // [RULE_10]
            end
            OCD_OPC_RET_EVEN: begin
                next_retCond = OCD_RET_IF_EVEN_PARITY; // [RULE_10]
            end
            OCD_OPC_RET_ODD: begin
                next_retCond = OCD_RET_IF_ODD_PARITY; // [RULE_10]
            end
            default: begin
                next_retCond = OCD_RET_IF_NONZERO; // [RULE_10]
            end
        endcase
    end

    // Strobe follows every offered byte
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            decValid <= 1'b0;
        end else begin
            decValid <= opValid;
        end
    end

    // Results hold until the next taken byte
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            opClass <= OCD_NONE;
        end else if (opValid) begin
            opClass <= next_opClass;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            decKnown <= 1'b0;
        end else if (opValid) begin
            decKnown <= next_decKnown;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            destField <= OCD_REG_B;
        end else if (opValid) begin
            destField <= next_destField; // [RULE_13]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            srcField <= OCD_REG_B;
        end else if (opValid) begin
            srcField <= next_srcField; // [RULE_13]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pairSel <= OCD_PAIR_BC;
        end else if (opValid) begin
            pairSel <= next_pairSel; // [RULE_11] [RULE_12]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            retCond <= OCD_RET_IF_NONZERO;
        end else if (opValid) begin
            retCond <= next_retCond; // [RULE_10]
        end
    end

    // Counts go to the timing sequencer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cycleCount <= 5'h00;
        end else if (opValid) begin
            cycleCount <= next_cycles; // [RULE_14]
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cycleCountTaken <= 5'h00;
        end else if (opValid) begin
            cycleCountTaken <= next_cyclesTaken; // [RULE_14]
        end
    end

endmodule

// ### verif/ocd_fetch_model.sv
// Purpose: Fetch-side model feeding opcode bytes
// Assumes: Requests come from the bench at the falling edge
// Notes:   An idle bus shows the inverse of the last byte
`timescale 1ns/1ps
module ocd_fetch_model (
    input  wire logic       core_clk,
    input  wire logic       reqValid,
    input  wire logic [7:0] reqByte,
    output logic            opValid,
    output logic [7:0]      opcode
);
    logic [7:0] last = 8'h00;
    always @(posedge core_clk) if (reqValid) last <= reqByte;
    assign opValid = reqValid;
    assign opcode  = reqValid ? reqByte : ~last;
endmodule

// ### verif/ocd_monitor.sv
// Purpose: Port checks for the opcode decoder
// Assumes: One clock, asynchronous active-low reset
// Notes:   Results land one edge after a taken byte
`timescale 1ns/1ps
module ocd_monitor
    import ocd_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic       opValid,
    input wire logic [7:0] opcode,
    input wire logic       decValid,
    input wire logic       decKnown,
    input wire logic [2:0] destField,
    input wire logic [1:0] pairSel,
    input wire logic [4:0] cycleCount,
    input wire logic [4:0] cycleCountTaken
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire [7:0] o = opcode;
    copy_cycles_a: assert property (
        opValid && o[7:6] == 2'b01 && o[5:3] != 3'h6 && o[2:0] != 3'h6
        |=> cycleCount == 5'h05 && destField == $past(o[5:3]))
        else $error("copy count");
    store_mem_a: assert property (
        opValid && o[7:3] == 5'h0E && o[2:0] != 3'h6
        |=> cycleCount == 5'h07) else $error("store count");
    load_mem_a: assert property (
        opValid && o[7:6] == 2'b01 && o[5:3] != 3'h6 && o[2:0] == 3'h6
        |=> cycleCount == 5'h07) else $error("load count");
    alu_reg_a: assert property (
        opValid && o[7:6] == 2'b10 && o[2:0] != 3'h6
        |=> cycleCount == 5'h04) else $error("alu reg count");
    alu_mem_a: assert property (
        opValid && o[7:6] == 2'b10 && o[2:0] == 3'h6
        |=> cycleCount == 5'h07) else $error("alu mem count");
    ret_count_a: assert property (
        opValid && o[7:6] == 2'b11 && o[5:4] != 2'h1 && o[2:0] == 3'h0
        |=> cycleCount == 5'h05 && cycleCountTaken == 5'h0B)
        else $error("return counts");
    pair_load_a: assert property (
        opValid && o[7:6] == 2'b00 && o[3:0] == 4'h1
        |=> cycleCount == 5'h0A && pairSel == $past(o[5:4]))
        else $error("pair load");
    push_count_a: assert property (
        opValid && o[7:6] == 2'b11 && o[5:4] != 2'h3 && o[3:0] == 4'h5
        |=> cycleCount == 5'h0B) else $error("push count");
    valid_follow_a: assert property (
        decValid == $past(opValid)) else $error("valid strobe");
    known_flag_a: assert property (
        opValid |=> decKnown == (cycleCount != 5'h00))
        else $error("known flag");
endmodule
bind ocd_decoder ocd_monitor i_ocd_monitor (.core_clk, .reset_n, .opValid,
    .opcode, .decValid, .decKnown, .destField, .pairSel, .cycleCount,
    .cycleCountTaken);

// ### verif/tb_ocd_decoder.sv
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Results one edge after each taken byte
// Notes:   Sweeps all bytes back to back, then random traffic
`timescale 1ns/1ps
module tb_ocd_decoder
    import ocd_pkg::*;
;
    logic core_clk = 0, reset_n = 0, reqValid = 0, opValid, decValid, decKnown;
    logic [7:0] reqByte = 8'h00, opcode;
    ocd_op_type opClass;
    ocd_cond_type retCond;
    logic [2:0] destField, srcField;
    logic [1:0] pairSel;
    logic [4:0] cycleCount, cycleCountTaken;
    logic [25:0] e, s, notes[$];
    int fails = 0, cmp_count = 0, seed = 10256;
    always #2.5 core_clk = ~core_clk;
    ocd_fetch_model i_ocd_fetch_model (.core_clk, .reqValid, .reqByte,
        .opValid, .opcode);
    ocd_decoder i_ocd_decoder (.core_clk, .reset_n, .opValid, .opcode,
        .opClass, .decValid, .decKnown, .destField, .srcField, .pairSel,
        .retCond, .cycleCount, .cycleCountTaken);
    task check(input string what, input logic [25:0] x, y);
        cmp_count++;
        if (x !== y) begin
            fails++;
            $display("wrong value %s exp %h got %h", what, x, y);
        end
    endtask
    function automatic logic [25:0] exp_of(input logic [7:0] o);
        ocd_op_type c = OCD_NONE;
        logic [4:0] n = 5'h00;
        logic [2:0] k = 3'h0;
        if (o[7:6] == 2'b01 && o != 8'h76) begin
            c = OCD_COPY_OP;
            n = 5'h05;
            if (o[5:3] == 3'h6) c = OCD_STORE_MEM;
            if (o[2:0] == 3'h6) c = OCD_LOAD_MEM;
            if (c != OCD_COPY_OP) n = 5'h07;
        end else if (o[7:6] == 2'b10) begin
            case (o[5:3])
                3'h0: c = OCD_ADD;
                3'h1: c = OCD_ADD_CARRY;
                3'h2: c = OCD_SUB;
                3'h3: c = OCD_MINUS_BORROW_OP;
                3'h4: c = OCD_AND_ACC_OP;
                3'h5: c = OCD_XOR_ACC_OP;
                3'h6: c = OCD_OR_ACC_OP;
                default: c = OCD_COMPARE_ACC_OP;
            endcase
            n = o[2:0] == 3'h6 ? 5'h07 : 5'h04;
        end else if (o[7:6] == 2'b00 && o[3:0] == 4'h1) begin
            c = OCD_LOAD_PAIR_IMMEDIATE;
            n = 5'h0A;
        end else if (o[7:6] == 2'b11 && o[3:0] == 4'h5 && o[5:4] != 2'h3) begin
            c = OCD_PUSH_PAIR;
            n = 5'h0B;
        end else if (o[7:6] == 2'b11 && o[2:0] == 3'h0 && o[5:4] != 2'h1) begin
            c = OCD_RET_COND;
            n = 5'h05;
            case (o[5:3])
                3'h0: k = OCD_RET_IF_NONZERO;
                3'h1: k = OCD_RET_IF_ZERO;
                3'h4: k = OCD_RET_IF_ODD_PARITY;
                3'h5: k = OCD_RET_IF_EVEN_PARITY;
                3'h6: k = OCD_RET_IF_PLUS;
                default: k = OCD_RET_IF_NEGATIVE;
            endcase
        end
        if (c == OCD_NONE) o = 8'h00;
        return {c, n, c == OCD_RET_COND ? 5'h0B : n, o[5:0], o[5:4], k};
    endfunction
    always @(posedge core_clk) begin
        #1;
        if (decValid === 1'b1) begin
            e = notes.size() > 0 ? notes.pop_front() : '1;
            s = {opClass, cycleCount, cycleCountTaken,
                decKnown ? {destField, srcField, pairSel} : 8'h00,
                opClass == OCD_RET_COND ? retCond : 3'h0};
            check("decode", e, s);
            check("known", 26'(e[25:21] != 0), 26'(decKnown));
        end
    end
    task stop_test;
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        reset_n = 1;
        check("idle", 26'h0, 26'({opClass, decValid, decKnown, cycleCount,
            cycleCountTaken}));
        for (int i = 0; i < 600; i++) begin
            @(negedge core_clk);
            reqValid = i < 256 || ($random(seed) & 1);
            reqByte = i < 256 ? i[7:0] : 8'($random(seed));
            if (reqValid) notes.push_back(exp_of(reqByte));
        end
        @(negedge core_clk) reqValid = 0;
        repeat (3) @(negedge core_clk);
        check("unanswered", 26'h0, 26'(notes.size()));
        stop_test;
    end
    initial begin
        #20000;
        fails++;
        stop_test;
    end
endmodule
